// >>> spmt_pkg.sv
// constants for the sector map parameter table slice: byte offsets,
// descriptor field encodings and the configuration index values.
// assumes the host reads the table one byte per request on the device clock.
//
// How it works
// - in the second detection descriptor, a masked bit reading one means the small sectors sit at the top.
// - both detection descriptors carry variable address length, variable latency and instruction 65h.
// - the second descriptor's address word reads 02h, 00h, 00h, 00h at offsets 54h to 57h.
// - the third descriptor's mask is 02h, selecting the uniform block size bit; with its end bit set, its low byte reads FDh.
// - the third descriptor has its end bit set and command bit clear; the second has both clear.
// - the third descriptor's address word reads 04h, 00h, 00h, 00h at offsets 5Ch to 5Fh.
// - the first map header reports a region count of 02h, meaning three regions.
// - the first map header carries configuration ID 01h.
// - the map header's low byte at offset 60h reads FEh.
// - the map header's reserved top byte at offset 63h reads FFh.
// - the second descriptor's mask is 04h, selecting the top or bottom placement bit.
// - configuration index 05h, third register bit set and first clear, means uniform 256-KB sectors.

package spmt_pkg;
	// ----------------------------------------
	// table geometry
	// ----------------------------------------
	localparam int unsigned SPMT_TABLE_LEN = 20;
	localparam int unsigned SPMT_IDX_W = 5;
	localparam logic [7:0] SPMT_TABLE_BASE = 8'h50;
	localparam logic [7:0] SPMT_TABLE_LAST = 8'h63;
	localparam logic [7:0] SPMT_OFS_DET2_CTRL = 8'h50;
	localparam logic [7:0] SPMT_OFS_DET2_ADDR = 8'h54;
	localparam logic [7:0] SPMT_OFS_DET3_CTRL = 8'h58;
	localparam logic [7:0] SPMT_OFS_DET3_ADDR = 8'h5c;
	localparam logic [7:0] SPMT_OFS_MAP1_HDR = 8'h60;
	localparam logic [7:0] SPMT_OFS_MAP1_RSVD = 8'h63;
	localparam logic [7:0] SPMT_UNMAPPED_BYTE = 8'hff;

	// ----------------------------------------
	// detection descriptor fields
	// ----------------------------------------
	localparam logic [1:0] SPMT_ADDR_LEN_VAR = 2'h3;
	localparam logic [1:0] SPMT_RFU2 = 2'h3;
	localparam logic [3:0] SPMT_LATENCY_VAR = 4'hf;
	localparam logic [7:0] SPMT_INSTR_READ_ANY = 8'h65;
	localparam logic [5:0] SPMT_RFU6 = 6'h3f;
	localparam logic SPMT_CMD_DESC = 1'b0;
	localparam logic [7:0] SPMT_MASK_TOP_SELECT = 8'h04;
	localparam logic [7:0] SPMT_MASK_UNIFORM_SIZE = 8'h02;
	localparam logic [31:0] SPMT_ADDR_NV_CFG_ONE = 32'h0000_0002;
	localparam logic [31:0] SPMT_ADDR_NV_CFG_THREE = 32'h0000_0004;

	// ----------------------------------------
	// first map header fields
	// ----------------------------------------
	localparam logic [7:0] SPMT_MAP_RSVD = 8'hff;
	localparam logic [7:0] SPMT_MAP1_REGION_CNT = 8'h02;
	localparam logic [7:0] SPMT_MAP1_CONFIG_ID = 8'h01;
	localparam logic [5:0] SPMT_MAP_LOW_RFU = 6'h3f;
	localparam logic SPMT_MAP_DESC = 1'b1;
	localparam logic SPMT_MAP1_END = 1'b0;

	// ----------------------------------------
	// configuration index values
	// ----------------------------------------
	localparam logic [7:0] SPMT_CFG_IDX_BOTTOM = 8'h01;
	localparam logic [7:0] SPMT_CFG_IDX_TOP = 8'h03;
	localparam logic [7:0] SPMT_CFG_IDX_UNIFORM = 8'h05;
	localparam logic [7:0] SPMT_CFG_IDX_BAD = 8'h07;
endpackage : spmt_pkg

// >>> spmt_detect_pack.sv
// builds one configuration detection descriptor (control and address dword).
// assumes its parameters are constants, so both outputs are fixed values.
`timescale 1ns/10ps
`default_nettype none

module spmt_detect_pack #(
	parameter logic [7:0] READ_MASK = 8'h00,
	parameter logic [31:0] CMD_ADDR = 32'h0000_0000,
	parameter logic END_FLAG = 1'b0
) (
	// descriptor words
	output logic [31:0] ctrl_dword_o,
	output logic [31:0] addr_dword_o
);
	import spmt_pkg::*;

	// variable length, latency and read-any-register for every descriptor
	assign ctrl_dword_o = {READ_MASK, SPMT_ADDR_LEN_VAR, SPMT_RFU2, SPMT_LATENCY_VAR,
		SPMT_INSTR_READ_ANY, SPMT_RFU6, SPMT_CMD_DESC, END_FLAG};
	assign addr_dword_o = CMD_ADDR;
endmodule : spmt_detect_pack

`default_nettype wire

// >>> spmt_byte_rom.sv
// byte-wide read-only table with a registered read port.
// assumes the table input is constant; unmapped reads return the filler byte.
`timescale 1ns/10ps
`default_nettype none

module spmt_byte_rom #(
	parameter int unsigned DEPTH = 20,
	parameter int unsigned IDX_W = 5
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// table contents
	input wire logic [8*DEPTH-1:0] table_i,
	// read port
	input wire logic rd_en_i,
	input wire logic hit_i,
	input wire logic [IDX_W-1:0] idx_i,
	output logic [7:0] data_o
);
	import spmt_pkg::*;

	logic [7:0] data;
	logic [7:0] next_data;

	always_comb begin
		next_data = data;
		if (rd_en_i) begin
			next_data = hit_i ? table_i[8*idx_i +: 8] : SPMT_UNMAPPED_BYTE;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			data <= SPMT_UNMAPPED_BYTE;
		end else begin
			data <= next_data;
		end
	end

	assign data_o = data;
endmodule : spmt_byte_rom

`default_nettype wire

// >>> spmt_sector_map_table.sv
// sector map parameter table slice: detection descriptors two and three
// and the first map header, read one byte per request.
// assumes requests come from host-facing logic on the same clock, and that
// the two configuration bits are held by nonvolatile logic on that clock.
`timescale 1ns/10ps
`default_nettype none

module spmt_sector_map_table (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// byte read port
	input wire logic rd_req_i,
	input wire logic [7:0] rd_offset_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic rd_hit_o,
	// live configuration bits
	input wire logic param_sector_top_select_i,
	input wire logic uniform_map_select_i,
	// decoded configuration
	output logic [7:0] cfg_index_o,
	output logic map_uniform_o,
	output logic cfg_supported_o
);
	import spmt_pkg::*;

	// ----------------------------------------
	// table contents
	// ----------------------------------------
	logic [31:0] det2_ctrl;
	logic [31:0] det2_addr;
	logic [31:0] det3_ctrl;
	logic [31:0] det3_addr;
	logic [31:0] map1_hdr;
	logic [8*SPMT_TABLE_LEN-1:0] table_flat;

	// placement bit of register one, not the last descriptor
	spmt_detect_pack #(
		.READ_MASK(SPMT_MASK_TOP_SELECT),
		.CMD_ADDR(SPMT_ADDR_NV_CFG_ONE),
		.END_FLAG(1'b0)
	) u_det2 (
		.ctrl_dword_o(det2_ctrl),
		.addr_dword_o(det2_addr)
	);

	// block size bit of register three closes the detection list
	spmt_detect_pack #(
		.READ_MASK(SPMT_MASK_UNIFORM_SIZE),
		.CMD_ADDR(SPMT_ADDR_NV_CFG_THREE),
		.END_FLAG(1'b1)
	) u_det3 (
		.ctrl_dword_o(det3_ctrl),
		.addr_dword_o(det3_addr)
	);

	assign map1_hdr = {SPMT_MAP_RSVD, SPMT_MAP1_REGION_CNT, SPMT_MAP1_CONFIG_ID,
		SPMT_MAP_LOW_RFU, SPMT_MAP_DESC, SPMT_MAP1_END};

	// little-endian: lowest offset in the low byte
	assign table_flat = {map1_hdr, det3_addr, det3_ctrl, det2_addr, det2_ctrl};

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	logic req_hit;
	logic [7:0] rel_offset;
	logic [SPMT_IDX_W-1:0] req_idx;

	assign req_hit = (rd_offset_i >= SPMT_TABLE_BASE) && (rd_offset_i <= SPMT_TABLE_LAST);
	assign rel_offset = rd_offset_i - SPMT_TABLE_BASE;
	assign req_idx = rel_offset[SPMT_IDX_W-1:0];

	spmt_byte_rom #(
		.DEPTH(SPMT_TABLE_LEN),
		.IDX_W(SPMT_IDX_W)
	) u_rom (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.table_i(table_flat),
		.rd_en_i(rd_req_i),
		.hit_i(req_hit),
		.idx_i(req_idx),
		.data_o(rd_data_o)
	);

	// ----------------------------------------
	// answer strobe
	// ----------------------------------------
	logic rd_valid;
	logic rd_hit;
	logic next_rd_valid;
	logic next_rd_hit;

	always_comb begin
		next_rd_valid = rd_req_i;
		next_rd_hit = rd_hit;
		if (rd_req_i) begin
			next_rd_hit = req_hit;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_valid <= 1'b0;
			rd_hit <= 1'b0;
		end else begin
			rd_valid <= next_rd_valid;
			rd_hit <= next_rd_hit;
		end
	end

	assign rd_valid_o = rd_valid;
	assign rd_hit_o = rd_hit;

	// ----------------------------------------
	// configuration index
	// ----------------------------------------
	// mirrors what a host derives from the two detection reads
	logic [7:0] cfg_index;
	logic [7:0] next_cfg_index;
	logic map_uniform;
	logic next_map_uniform;
	logic cfg_supported;
	logic next_cfg_supported;

	always_comb begin
		case ({uniform_map_select_i, param_sector_top_select_i})
			2'b00: next_cfg_index = SPMT_CFG_IDX_BOTTOM;
			2'b01: next_cfg_index = SPMT_CFG_IDX_TOP;
			2'b10: next_cfg_index = SPMT_CFG_IDX_UNIFORM;
			default: next_cfg_index = SPMT_CFG_IDX_BAD;
		endcase
		// flags decoded ahead of the register so they move with the index
		next_map_uniform = (next_cfg_index == SPMT_CFG_IDX_UNIFORM);
		// both bits set is not a supported map combination
		next_cfg_supported = (next_cfg_index != SPMT_CFG_IDX_BAD);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_index <= SPMT_CFG_IDX_BOTTOM;
			map_uniform <= 1'b0;
			cfg_supported <= 1'b1;
		end else begin
			cfg_index <= next_cfg_index;
			map_uniform <= next_map_uniform;
			cfg_supported <= next_cfg_supported;
		end
	end

	assign cfg_index_o = cfg_index;
	assign map_uniform_o = map_uniform;
	assign cfg_supported_o = cfg_supported;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence req_at(logic [7:0] ofs);
		rd_req_i && (rd_offset_i == ofs);
	endsequence

	sequence ans_byte(logic [7:0] val);
		rd_valid_o && rd_hit_o && (rd_data_o == val);
	endsequence

	// four back-to-back byte requests covering one dword
	sequence word_req(logic [7:0] ofs);
		req_at(ofs) ##1 req_at(ofs + 8'h01) ##1 req_at(ofs + 8'h02) ##1 req_at(ofs + 8'h03);
	endsequence

	// at the last request two answers lie behind, the third is current and the fourth one ahead
	sequence word_ans(logic [31:0] w);
		($past(rd_data_o, 2) == w[7:0]) && ($past(rd_data_o) == w[15:8]) && rd_valid_o && rd_hit_o
			&& (rd_data_o == w[23:16]) ##1 ans_byte(w[31:24]);
	endsequence

	sequence cfg_is(logic [7:0] idx, logic uni, logic sup);
		(cfg_index_o == idx) && (map_uniform_o == uni) && (cfg_supported_o == sup);
	endsequence

	det2_ctrl_low_a: assert property (req_at(SPMT_OFS_DET2_CTRL) |=> ans_byte(8'hfc))
		else $error("second descriptor low byte wrong");
	det2_mask_a: assert property (req_at(8'h53) |=> ans_byte(8'h04))
		else $error("second descriptor mask wrong");
	det2_top_sense_a: assert property (req_at(8'h53) ##1 rd_valid_o |-> rd_data_o[2])
		else $error("placement bit not selected by mask");
	instr_byte_a: assert property (rd_req_i && (rd_offset_i inside {8'h51, 8'h59}) |=> ans_byte(8'h65))
		else $error("detection instruction not read-any-register");
	latency_len_a: assert property (rd_req_i && (rd_offset_i inside {8'h52, 8'h5a}) |=> ans_byte(8'hff))
		else $error("address length or latency not variable");
	det2_addr_a: assert property (req_at(SPMT_OFS_DET2_ADDR) ##1 req_at(8'h55) |->
		ans_byte(8'h02) ##1 ans_byte(8'h00))
		else $error("second descriptor address word wrong");
	det3_low_a: assert property (req_at(SPMT_OFS_DET3_CTRL) |=> ans_byte(8'hfd))
		else $error("third descriptor low byte wrong");
	det3_end_a: assert property (req_at(SPMT_OFS_DET3_CTRL) |=> rd_data_o[0] && !rd_data_o[1])
		else $error("third descriptor end or command bit wrong");
	det3_mask_a: assert property (req_at(8'h5b) |=> ans_byte(8'h02))
		else $error("third descriptor mask wrong");
	det3_addr_a: assert property (req_at(SPMT_OFS_DET3_ADDR) |=> ans_byte(8'h04))
		else $error("third descriptor address low byte wrong");
	det3_addr_hi_a: assert property (rd_req_i && (rd_offset_i inside {8'h5d, 8'h5e, 8'h5f})
		|=> ans_byte(8'h00))
		else $error("third descriptor address high bytes nonzero");
	hdr_low_a: assert property (req_at(SPMT_OFS_MAP1_HDR) |=> ans_byte(8'hfe))
		else $error("map header low byte wrong");
	hdr_cfg_id_a: assert property (req_at(8'h61) |=> ans_byte(8'h01))
		else $error("configuration id wrong");
	hdr_regions_a: assert property (req_at(8'h62) |=> ans_byte(8'h02))
		else $error("region count wrong");
	hdr_rsvd_a: assert property (req_at(SPMT_OFS_MAP1_RSVD) |=> ans_byte(8'hff))
		else $error("map header reserved byte wrong");
	uniform_idx_a: assert property (reset_n_i && uniform_map_select_i && !param_sector_top_select_i
		|=> cfg_is(8'h05, 1'b1, 1'b1))
		else $error("uniform map index wrong");

	// same offset twice must give the same byte
	logic [7:0] last_ofs;
	logic [7:0] last_byte;
	logic last_ok;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			last_ofs <= 8'h00;
			last_byte <= 8'h00;
			last_ok <= 1'b0;
		end else begin
			if (rd_req_i) begin
				last_ofs <= rd_offset_i;
			end
			if (rd_valid_o) begin
				last_byte <= rd_data_o;
				last_ok <= 1'b1;
			end
		end
	end

	repeat_stable_a: assert property (last_ok && rd_req_i && !rd_valid_o && (rd_offset_i == last_ofs)
		|=> rd_data_o == last_byte)
		else $error("table byte changed between reads");
	unmapped_a: assert property (rd_req_i && !req_hit |=> rd_valid_o && !rd_hit_o && rd_data_o == 8'hff)
		else $error("unmapped offset answer wrong");

	// ----------------------------------------
	// whole dword checks
	// ----------------------------------------
	// a swapped byte order shows up here even when every byte value exists somewhere
	det2_ctrl_word_a: assert property (word_req(SPMT_OFS_DET2_CTRL) |-> word_ans(32'h04ff_65fc))
		else $error("second descriptor control dword wrong");
	det2_addr_word_a: assert property (word_req(SPMT_OFS_DET2_ADDR) |-> word_ans(32'h0000_0002))
		else $error("second descriptor address dword wrong");
	det3_ctrl_word_a: assert property (word_req(SPMT_OFS_DET3_CTRL) |-> word_ans(32'h02ff_65fd))
		else $error("third descriptor control dword wrong");
	det3_addr_word_a: assert property (word_req(SPMT_OFS_DET3_ADDR) |-> word_ans(32'h0000_0004))
		else $error("third descriptor address dword wrong");
	hdr_word_a: assert property (word_req(SPMT_OFS_MAP1_HDR) |-> word_ans(32'hff02_01fe))
		else $error("map header dword wrong");

	// ----------------------------------------
	// answer timing and configuration checks
	// ----------------------------------------
	valid_follow_a: assert property (rd_req_i |=> rd_valid_o)
		else $error("request not answered next cycle");
	// answer data and hit move only on a request; the strobe drops without one
	answer_hold_a: assert property (!rd_req_i |=>
		!rd_valid_o && $stable(rd_data_o) && $stable(rd_hit_o))
		else $error("answer changed without a request");
	hit_level_a: assert property (rd_req_i && req_hit |=> rd_hit_o)
		else $error("table offset not flagged as hit");
	det2_addr_hi_a: assert property (rd_req_i && (rd_offset_i inside {8'h55, 8'h56, 8'h57})
		|=> ans_byte(8'h00))
		else $error("second descriptor address high bytes nonzero");
	det2_cmd_bits_a: assert property (req_at(SPMT_OFS_DET2_CTRL) |=> !rd_data_o[0] && !rd_data_o[1])
		else $error("second descriptor end or command bit set");
	hdr_map_desc_a: assert property (req_at(SPMT_OFS_MAP1_HDR) |=> rd_data_o[1] && !rd_data_o[0])
		else $error("map header descriptor bits wrong");

	// reset sits in the antecedent: the edge that releases reset still loads the reset index
	cfg_bottom_a: assert property (reset_n_i && !uniform_map_select_i && !param_sector_top_select_i
		|=> cfg_is(8'h01, 1'b0, 1'b1))
		else $error("bottom map index wrong");
	cfg_top_a: assert property (reset_n_i && !uniform_map_select_i && param_sector_top_select_i
		|=> cfg_is(8'h03, 1'b0, 1'b1))
		else $error("top map index wrong");
	cfg_bad_a: assert property (reset_n_i && uniform_map_select_i && param_sector_top_select_i
		|=> cfg_is(8'h07, 1'b0, 1'b0))
		else $error("unsupported map index wrong");
endmodule : spmt_sector_map_table

`default_nettype wire

// >>> spmt_host_model.sv
// host-side partner: issues table byte reads back to back and collects answers.
// assumes the table answers one clock after each request it takes.
`timescale 1ns/10ps
`default_nettype none

module spmt_host_model (
	// clock
	input wire logic clk_i,
	// read port, host side
	output logic rd_req_o,
	output logic [7:0] rd_offset_o,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i,
	input wire logic rd_hit_i
);
	initial begin
		rd_req_o = 1'b0;
		rd_offset_o = 8'h00;
	end

	// answers come back as {hit, data}; a missing strobe yields unknown data
	task automatic read_seq(input logic [7:0] ofs [$], output logic [8:0] ans [$]);
		int n;
		n = ofs.size();
		ans = {};
		for (int i = 0; i < n + 2; i++) begin
			@(posedge clk_i);
			if (i >= 2) begin
				ans.push_back(rd_valid_i === 1'b1 ? {rd_hit_i, rd_data_i} : 9'h1xx);
			end
			if (i < n) begin
				rd_req_o <= 1'b1;
				rd_offset_o <= ofs[i];
			end else begin
				// idle offset keeps toggling so a stale decode cannot pass
				rd_req_o <= 1'b0;
				rd_offset_o <= ~rd_offset_o;
			end
		end
	endtask : read_seq
endmodule : spmt_host_model
`default_nettype wire

// >>> spmt_sector_map_table_tb.sv
// self-checking bench for the sector map parameter table slice.
// assumes the host model drives the read port; the bench drives config bits.
`timescale 1ns/10ps
`default_nettype none

module spmt_sector_map_table_tb;
	import spmt_pkg::*;
	typedef struct packed {
		logic [7:0] ofs;
		logic [8:0] ans;
	} spmt_row_s;
	logic clk_i, reset_n_i, rd_req_i, rd_valid_o, rd_hit_o, top_sel, uni_sel, map_uniform_o, cfg_supported_o;
	logic [7:0] rd_offset_i, rd_data_o, cfg_index_o;
	int err_count, check_count;
	logic [7:0] ofs_q [$];
	logic [8:0] ans_q [$];
	// answer is {hit, byte}; last four rows lie outside the table
	spmt_row_s rows [24] = '{'{8'h50, 9'h1fc}, '{8'h51, 9'h165}, '{8'h52, 9'h1ff}, '{8'h53, 9'h104},
		'{8'h54, 9'h102}, '{8'h55, 9'h100}, '{8'h56, 9'h100}, '{8'h57, 9'h100},
		'{8'h58, 9'h1fd}, '{8'h59, 9'h165}, '{8'h5a, 9'h1ff}, '{8'h5b, 9'h102},
		'{8'h5c, 9'h104}, '{8'h5d, 9'h100}, '{8'h5e, 9'h100}, '{8'h5f, 9'h100},
		'{8'h60, 9'h1fe}, '{8'h61, 9'h101}, '{8'h62, 9'h102}, '{8'h63, 9'h1ff},
		'{8'h4f, 9'h0ff}, '{8'h64, 9'h0ff}, '{8'h00, 9'h0ff}, '{8'hff, 9'h0ff}};
	// {uniform, top, index, map uniform, supported}
	logic [11:0] cfg_rows [4] = '{12'h005, 12'h40d, 12'h817, 12'hc1c};

	spmt_sector_map_table spmt_sector_map_table_i (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.rd_req_i(rd_req_i),
		.rd_offset_i(rd_offset_i),
		.rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o),
		.rd_hit_o(rd_hit_o),
		.param_sector_top_select_i(top_sel),
		.uniform_map_select_i(uni_sel),
		.cfg_index_o(cfg_index_o),
		.map_uniform_o(map_uniform_o),
		.cfg_supported_o(cfg_supported_o)
	);

	spmt_host_model spmt_host_model_i (
		.clk_i(clk_i),
		.rd_req_o(rd_req_i),
		.rd_offset_o(rd_offset_i),
		.rd_data_i(rd_data_o),
		.rd_valid_i(rd_valid_o),
		.rd_hit_i(rd_hit_o)
	);

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic close_out();
		if (err_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	task automatic check_reset();
		check({rd_valid_o, rd_hit_o, rd_data_o}, 10'h0ff);
		check({cfg_index_o, map_uniform_o, cfg_supported_o}, 10'h005);
	endtask : check_reset

	// ----------------------------------------
	// clock, watchdog, sequence
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// whole run is about 60 cycles; allow fifty times that
	initial begin
		#60000;
		err_count++;
		close_out();
	end

	initial begin
		err_count = 0;
		check_count = 0;
		reset_n_i = 1'b0;
		top_sel = 1'b0;
		uni_sel = 1'b0;
		repeat (12) @(posedge clk_i);
		check_reset();
		reset_n_i <= 1'b1;
		// every row read back to back, no idle cycle between requests
		foreach (rows[i]) ofs_q.push_back(rows[i].ofs);
		spmt_host_model_i.read_seq(ofs_q, ans_q);
		foreach (rows[i]) check({1'b0, ans_q[i]}, {1'b0, rows[i].ans});
		foreach (cfg_rows[i]) begin
			@(posedge clk_i);
			{uni_sel, top_sel} <= cfg_rows[i][11:10];
			repeat (2) @(posedge clk_i);
			check({cfg_index_o, map_uniform_o, cfg_supported_o}, cfg_rows[i][9:0]);
		end
		// unsupported config must not disturb the table bytes; the second read repeats the offset
		ofs_q = '{8'h58};
		repeat (2) begin
			spmt_host_model_i.read_seq(ofs_q, ans_q);
			check({1'b0, ans_q[0]}, 10'h1fd);
		end
		@(posedge clk_i);
		check({rd_valid_o, rd_hit_o, rd_data_o}, 10'h1fd);
		// reset in mid-run with both config bits high
		reset_n_i <= 1'b0;
		@(posedge clk_i);
		check_reset();
		reset_n_i <= 1'b1;
		ofs_q = '{8'h63, 8'h60};
		spmt_host_model_i.read_seq(ofs_q, ans_q);
		check({1'b0, ans_q[0]}, 10'h1ff);
		check({1'b0, ans_q[1]}, 10'h1fe);
		close_out();
	end
endmodule : spmt_sector_map_table_tb
`default_nettype wire
